//--- design/mmm_pkg.sv
`default_nettype none
// Shared constants and types of the multi-store memory manager
package mmm_pkg;
  // Storage codes seen on the request port
  localparam logic [7:0] STORE_FLASH_LEGACY = 8'h01;
  localparam logic [7:0] STORE_INTERNAL_RAM = 8'h02;
  localparam logic [7:0] STORE_INTERNAL_EEPROM = 8'h03;
  localparam logic [7:0] STORE_EXTERNAL_FIRST = 8'h10;
  localparam logic [7:0] STORE_EXTERNAL_LAST = 8'h17;
  localparam logic [7:0] STORE_FLASH_LOW = 8'h80;
  localparam logic [7:0] STORE_FLASH_HIGH = 8'h81;
  // Address map of the stores
  localparam logic [23:0] RAM_BASE = 24'h000100;
  localparam logic [23:0] FLASH_HIGH_BASE = 24'h010000;
  localparam logic [16:0] RAM_LAST = 17'h008FF;
  localparam logic [16:0] EE_LAST = 17'h003FF;
  localparam logic [16:0] OFF_LAST = 17'h0FFFF;
  localparam logic [15:0] FLASH_LOW_FIRST = 16'hC000;
  localparam logic [23:0] BLOCK_MASK = 24'hFFFFC0;
  localparam logic [6:0] BLOCK_LEN = 7'h40;
  localparam int BLOCK_BYTES = 64;
  // Serial memory control byte and read filler
  localparam logic [7:0] EXT_CTRL_BASE = 8'hB0;
  localparam logic [7:0] READ_FILL = 8'hFF;
  // Total write attempts before giving up
  localparam logic [6:0] RETRY_MAX = 7'd100;
  // Serial bus timing, a quarter bit period in clock cycles
  localparam int CLK_HZ = 200000000;
  localparam int SLOW_HZ = 100000;
  localparam int FAST_HZ = 400000;
  localparam logic [9:0] QTR_SLOW = 10'(CLK_HZ / (4 * SLOW_HZ));
  localparam logic [9:0] QTR_FAST = 10'(CLK_HZ / (4 * FAST_HZ));
  // Serial transaction step numbers
  localparam logic [3:0] STEP_RD_RESTART = 4'h4;
  localparam logic [3:0] STEP_RD_DATA = 4'h6;
  localparam logic [3:0] STEP_RD_STOP = 4'h7;
  localparam logic [3:0] STEP_WR_STOP = 4'h5;
  localparam logic [3:0] STEP_WR_RESTART = 4'h6;
  localparam logic [3:0] STEP_WR_POLL = 4'h7;
  localparam logic [3:0] STEP_WR_END = 4'h8;
  // Main sequence, Gray coded along the flash write path from ST_IDLE to ST_FINISH
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_LOAD = 3'h1, ST_SCAN = 3'h3, ST_ERASE = 3'h2,
    ST_PROG = 3'h6, ST_VERIFY = 3'h7, ST_FINISH = 3'h5
  } mmm_state_t;
  // Operation on the internal memory port
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_WRITE = 2'h1, OP_ERASE = 2'h2} mmm_op_t;
  // Internal store selected on the memory port
  typedef enum logic [1:0] {SEL_RAM = 2'h0, SEL_EEPROM = 2'h1, SEL_FLASH = 2'h2} mmm_sel_t;
  // Kind of one serial bus step
  typedef enum logic [1:0] {K_START = 2'h0, K_BYTE = 2'h1, K_STOP = 2'h2} mmm_kind_t;
endpackage
`default_nettype wire

//--- design/mmm_memory_manager.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Code 02 maps RAM offsets from 0x0100
// - Code 03 addresses internal EEPROM directly
// - Codes 10-17 pick serial memories B0 upward
// - Code 80 uses flash offsets C000-FFFF unchanged
// - Code 81 maps offsets onto upper flash
// - Code 01 acts as upper flash
// - Flash below C000 is always refused
// - RAM outside window is unreachable
// - Reads stream consecutive bytes to requester
// - Writes take alternate source when nonzero
// - Skip writing when contents already match, except RAM
// - Verify except RAM, 100 attempts in all, then fail
// - Flash writes via codes 80 and 81 rewrite whole 64-byte block
// - Flash writes hold interrupts, suspend radio
// - Serial transfers hold interrupts, suspend radio
// - Up to eight serial memories reached
// - Bus rate 100kHz or 400kHz selectable
// - Absent serial memory raises memory failure
module mmm_memory_manager
  import mmm_pkg::*;
#(
  parameter int MAX_RUN = BLOCK_BYTES,
  parameter int POLL_MAX = 1000
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic read_run_request_i,
  input wire logic write_run_request_i,
  input wire logic [7:0] storage_code_i,
  input wire logic [15:0] offset_i,
  input wire logic [6:0] byte_count_i,
  input wire logic [15:0] alt_pointer_i,
  input wire logic serial_fast_i,
  input wire logic [7:0] primary_data_i,
  input wire logic primary_valid_i,
  output logic primary_ready_o,
  input wire logic [7:0] alternate_data_i,
  input wire logic alternate_valid_i,
  output logic alternate_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic memory_failure_error_o,
  output logic irq_hold_o,
  output logic radio_suspend_o,
  output logic mem_req_o,
  output logic [1:0] mem_op_o,
  output logic [1:0] mem_sel_o,
  output logic [23:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);

  // Refuse sizes the image buffer and poll counter cannot hold
  if (MAX_RUN < 1 || MAX_RUN > BLOCK_BYTES) $error("MAX_RUN must be 1 to 64");
  if (POLL_MAX < 1 || POLL_MAX > 1023) $error("POLL_MAX must be 1 to 1023");

  // Physical address of a request offset
  function automatic logic [23:0] map_phys(input logic [7:0] c, input logic [15:0] o);
    if (c == STORE_INTERNAL_RAM)
      map_phys = RAM_BASE + {8'h00, o};
    else if (c == STORE_FLASH_HIGH || c == STORE_FLASH_LEGACY)
      map_phys = FLASH_HIGH_BASE + {8'h00, o};
    else
      map_phys = {8'h00, o};
  endfunction

  // True when code, offset and count name a reachable run
  function automatic logic req_ok(input logic [7:0] c, input logic [15:0] o,
                                  input logic [6:0] n);
    logic [16:0] e;
    e = {1'b0, o} + {10'h000, n} - 17'h00001;
    if (n == 7'h00 || n > 7'(MAX_RUN))
      req_ok = 1'b0;
    else if (c == STORE_INTERNAL_RAM)
      req_ok = (e <= RAM_LAST);
    else if (c == STORE_INTERNAL_EEPROM)
      req_ok = (e <= EE_LAST);
    else if (c == STORE_FLASH_LOW)
      req_ok = (o >= FLASH_LOW_FIRST) && (e <= OFF_LAST);
    else if (c == STORE_FLASH_HIGH || c == STORE_FLASH_LEGACY)
      req_ok = (e <= OFF_LAST);
    else if (c >= STORE_EXTERNAL_FIRST && c <= STORE_EXTERNAL_LAST)
      req_ok = (e <= OFF_LAST);
    else
      req_ok = 1'b0;
  endfunction

  // Kind of each serial step; read and write sequences differ
  function automatic mmm_kind_t step_kind(input logic w, input logic [3:0] s);
    if (s == 4'h0 || (!w && s == STEP_RD_RESTART) || (w && s == STEP_WR_RESTART))
      step_kind = K_START;
    else if ((!w && s == STEP_RD_STOP) || (w && (s == STEP_WR_STOP || s == STEP_WR_END)))
      step_kind = K_STOP;
    else
      step_kind = K_BYTE;
  endfunction

  // Byte sent in each serial step
  function automatic logic [7:0] step_byte(input logic [3:0] s, input logic [7:0] ctl,
                                           input logic [15:0] a, input logic [7:0] d);
    case (s)
      4'h1, 4'h7: step_byte = ctl;
      4'h2: step_byte = a[15:8];
      4'h3: step_byte = a[7:0];
      4'h4: step_byte = d;
      4'h5: step_byte = ctl | 8'h01;
      default: step_byte = READ_FILL;
    endcase
  endfunction

  mmm_state_t st; // Main sequence
  logic [7:0] code; // Latched storage code
  logic is_wr; // Request is a write
  logic alt; // Alternate source chosen
  logic ext; // Serial memory store
  logic flash; // Flash store
  logic vol; // Volatile RAM store
  logic [6:0] cnt; // Requested byte count
  logic [5:0] lo; // First requested byte within the image
  logic [6:0] len; // Bytes scanned per pass
  logic [23:0] base; // Address of image byte zero
  logic [6:0] k; // Load index
  logic [6:0] pos; // Scan index
  logic dirty; // Old contents differ
  logic mism; // Verify mismatch seen
  logic [6:0] tries; // Write attempts so far
  logic op_pend; // One memory operation outstanding
  logic fin_err; // Finish with memory failure
  logic fin_ref; // Finish as refused
  logic [7:0] img [BLOCK_BYTES]; // Image of the bytes to store
  logic int_done, ext_done; // Operation completion pulses
  logic [7:0] int_rdata, ext_rdata; // Bytes read back
  logic ext_fail; // Serial memory did not answer
  logic [7:0] tail_data; // Second buffer entry
  logic tail_v;

  // Combined view of the two operation engines
  logic op_done, op_fail, launch, last, in_rng, diff, take, src_v;
  logic [7:0] op_rdata, src_d;
  logic [23:0] op_addr;
  mmm_op_t op_kind;
  always_comb
  begin
    op_done = ext ? ext_done : int_done;
    op_fail = ext & ext_fail;
    op_rdata = ext ? ext_rdata : int_rdata;
    op_addr = base + {17'h00000, pos};
    last = (pos == len - 7'h01);
    in_rng = (pos >= {1'b0, lo}) && (pos < {1'b0, lo} + cnt);
    diff = (op_rdata != img[pos[5:0]]);
    src_v = alt ? alternate_valid_i : primary_valid_i;
    src_d = alt ? alternate_data_i : primary_data_i;
    take = (st == ST_LOAD) && src_v && (alt ? alternate_ready_o : primary_ready_o);
    if (st == ST_ERASE)
      op_kind = OP_ERASE;
    else if (st == ST_PROG)
      op_kind = OP_WRITE;
    else
      op_kind = OP_READ;
    // Reads start only with room for the answer, so no byte is lost
    launch = (st == ST_SCAN || st == ST_ERASE || st == ST_PROG || st == ST_VERIFY)
             && !op_pend && !(st == ST_SCAN && !is_wr && tail_v);
  end

  // Main request sequence
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= ST_IDLE;
      code <= 8'h00;
      {is_wr, alt, ext, flash, vol, dirty, mism, op_pend, fin_err, fin_ref} <= 10'h000;
      cnt <= 7'h00;
      lo <= 6'h00;
      len <= 7'h00;
      base <= 24'h000000;
      k <= 7'h00;
      pos <= 7'h00;
      tries <= 7'h00;
      primary_ready_o <= 1'b0;
      alternate_ready_o <= 1'b0;
    end
    else
    begin
      if (launch)
        op_pend <= 1'b1;
      else if (op_done)
        op_pend <= 1'b0;
      case (st)
        ST_IDLE:
        begin
          fin_err <= 1'b0;
          fin_ref <= 1'b0;
          if (read_run_request_i || write_run_request_i)
          begin
            code <= storage_code_i;
            cnt <= byte_count_i;
            is_wr <= write_run_request_i;
            alt <= |alt_pointer_i;
            ext <= storage_code_i >= STORE_EXTERNAL_FIRST
                   && storage_code_i <= STORE_EXTERNAL_LAST;
            flash <= storage_code_i == STORE_FLASH_LOW || storage_code_i == STORE_FLASH_HIGH
                     || storage_code_i == STORE_FLASH_LEGACY;
            vol <= storage_code_i == STORE_INTERNAL_RAM;
            k <= 7'h00;
            pos <= 7'h00;
            dirty <= 1'b0;
            tries <= 7'h01;
            if (write_run_request_i && storage_code_i[7])
            begin
              base <= map_phys(storage_code_i, offset_i) & BLOCK_MASK;
              len <= BLOCK_LEN;
              lo <= offset_i[5:0];
            end
            else
            begin
              base <= map_phys(storage_code_i, offset_i);
              len <= byte_count_i;
              lo <= 6'h00;
            end
            // A flash write through codes 80 and 81 may not straddle two blocks
            if (!req_ok(storage_code_i, offset_i, byte_count_i) || (write_run_request_i
                && storage_code_i[7] && ({1'b0, offset_i[5:0]} + byte_count_i) > BLOCK_LEN))
            begin
              fin_ref <= 1'b1;
              st <= ST_FINISH;
            end
            else if (write_run_request_i)
            begin
              primary_ready_o <= ~|alt_pointer_i;
              alternate_ready_o <= |alt_pointer_i;
              st <= ST_LOAD;
            end
            else
              st <= ST_SCAN;
          end
        end
        ST_LOAD:
        begin
          if (take)
          begin
            k <= k + 7'h01;
            if (k == cnt - 7'h01)
            begin
              primary_ready_o <= 1'b0;
              alternate_ready_o <= 1'b0;
              // RAM is volatile and needs no compare
              st <= vol ? ST_PROG : ST_SCAN;
            end
          end
        end
        ST_SCAN, ST_VERIFY:
        begin
          if (op_done)
          begin
            pos <= last ? 7'h00 : pos + 7'h01;
            if (op_fail)
            begin
              fin_err <= 1'b1;
              st <= ST_FINISH;
            end
            else if (st == ST_SCAN)
            begin
              if (is_wr && in_rng && diff)
                dirty <= 1'b1;
              if (last)
                st <= (!is_wr || !(dirty || (in_rng && diff))) ? ST_FINISH
                      : (flash ? ST_ERASE : ST_PROG);
            end
            else
            begin
              if (diff)
                mism <= 1'b1;
              if (last && (mism || diff))
              begin
                if (tries == RETRY_MAX)
                begin
                  fin_err <= 1'b1;
                  st <= ST_FINISH;
                end
                else
                begin
                  tries <= tries + 7'h01;
                  st <= flash ? ST_ERASE : ST_PROG;
                end
              end
              else if (last)
                st <= ST_FINISH;
            end
          end
        end
        ST_ERASE:
        begin
          if (op_done)
          begin
            pos <= 7'h00;
            st <= ST_PROG;
          end
        end
        ST_PROG:
        begin
          mism <= 1'b0;
          if (op_done)
          begin
            pos <= last ? 7'h00 : pos + 7'h01;
            if (op_fail)
            begin
              fin_err <= 1'b1;
              st <= ST_FINISH;
            end
            else if (last)
              st <= vol ? ST_FINISH : ST_VERIFY;
          end
        end
        default:
          st <= ST_IDLE;
      endcase
    end
  end

  // Image of the block; data only, so no reset
  always_ff @(posedge clk_i)
  begin
    if (take)
      img[lo + k[5:0]] <= src_d;
    else if (st == ST_SCAN && is_wr && op_done && !in_rng)
      img[pos[5:0]] <= op_rdata;
  end

  // Internal memory port, held until acknowledged
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      mem_req_o <= 1'b0;
      mem_op_o <= OP_READ;
      mem_sel_o <= SEL_RAM;
      mem_addr_o <= 24'h000000;
      mem_wdata_o <= 8'h00;
      int_done <= 1'b0;
      int_rdata <= 8'h00;
    end
    else
    begin
      int_done <= mem_req_o && mem_ack_i;
      if (mem_req_o && mem_ack_i)
      begin
        mem_req_o <= 1'b0;
        int_rdata <= mem_rdata_i;
      end
      else if (launch && !ext)
      begin
        mem_req_o <= 1'b1;
        mem_op_o <= op_kind;
        mem_sel_o <= flash ? SEL_FLASH : (vol ? SEL_RAM : SEL_EEPROM);
        mem_addr_o <= op_addr;
        mem_wdata_o <= img[pos[5:0]];
      end
    end
  end

  // Bus line synchronisers; only the second stage is read
  logic sda_m, sda_s, scl_m, scl_s;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {sda_m, sda_s, scl_m, scl_s} <= 4'hF;
    else
      {sda_m, sda_s, scl_m, scl_s} <= {sda_i, sda_m, scl_i, scl_m};
  end

  // Serial memory engine, one byte per transaction
  logic i_busy, i_wr, ack_bad;
  logic [3:0] stp, bitn;
  logic [1:0] ph;
  logic [9:0] qcnt, polls;
  logic [8:0] txsh;
  logic [7:0] rxsh, ctl, wbyte;
  logic [15:0] eaddr;
  mmm_kind_t kind;
  assign kind = step_kind(i_wr, stp);
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      {i_busy, i_wr, ack_bad, ext_done, ext_fail} <= 5'h00;
      {stp, bitn, ph} <= 10'h000;
      qcnt <= 10'h000;
      polls <= 10'h000;
      txsh <= 9'h1FF;
      {rxsh, ext_rdata, ctl, wbyte} <= 32'h00000000;
      eaddr <= 16'h0000;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end
    else
    begin
      ext_done <= 1'b0;
      if (!i_busy)
      begin
        if (launch && ext)
        begin
          i_busy <= 1'b1;
          i_wr <= (op_kind == OP_WRITE);
          ctl <= EXT_CTRL_BASE | {4'h0, code[2:0], 1'b0};
          eaddr <= op_addr[15:0];
          wbyte <= img[pos[5:0]];
          {stp, bitn, ph} <= 10'h000;
          ext_fail <= 1'b0;
          polls <= 10'h000;
          qcnt <= serial_fast_i ? QTR_FAST : QTR_SLOW;
        end
      end
      else if (qcnt != 10'h000)
        qcnt <= qcnt - 10'h001;
      // A slave stretching the clock holds the high phase
      else if (!(ph == 2'h2 && kind != K_STOP && !scl_s && scl_oe_n_o))
      begin
        qcnt <= serial_fast_i ? QTR_FAST : QTR_SLOW;
        ph <= ph + 2'h1;
        case (kind)
          K_START:
            case (ph)
              2'h0: {sda_oe_n_o, scl_oe_n_o} <= 2'b10;
              2'h1: scl_oe_n_o <= 1'b1;
              2'h2: sda_oe_n_o <= 1'b0;
              default: scl_oe_n_o <= 1'b0;
            endcase
          K_STOP:
            case (ph)
              2'h0: {sda_oe_n_o, scl_oe_n_o} <= 2'b00;
              2'h1: scl_oe_n_o <= 1'b1;
              2'h2: sda_oe_n_o <= 1'b1;
              default: scl_oe_n_o <= 1'b1;
            endcase
          default:
            case (ph)
              2'h0: {sda_oe_n_o, scl_oe_n_o} <= {txsh[8], 1'b0};
              2'h1: scl_oe_n_o <= 1'b1;
              2'h2:
              begin
                if (bitn == 4'h8)
                  ack_bad <= sda_s;
                else
                  rxsh <= {rxsh[6:0], sda_s};
              end
              default:
              begin
                scl_oe_n_o <= 1'b0;
                txsh <= {txsh[7:0], 1'b1};
              end
            endcase
        endcase
        if (ph == 2'h3 && kind == K_BYTE && bitn != 4'h8)
          bitn <= bitn + 4'h1;
        else if (ph == 2'h3)
        begin
          bitn <= 4'h0;
          // The first stop of a write leads on to acknowledge polling
          if (kind == K_STOP && !(i_wr && stp == STEP_WR_STOP))
          begin
            i_busy <= 1'b0;
            ext_done <= 1'b1;
          end
          else if (kind == K_BYTE && i_wr && stp == STEP_WR_POLL && ack_bad)
          begin
            // poll until the write cycle ends
            polls <= polls + 10'h001;
            if (polls == 10'(POLL_MAX - 1))
              ext_fail <= 1'b1;
            stp <= (polls == 10'(POLL_MAX - 1)) ? STEP_WR_END : STEP_WR_RESTART;
          end
          else if (kind == K_BYTE && ack_bad && !(!i_wr && stp == STEP_RD_DATA))
          begin
            ext_fail <= 1'b1;
            stp <= i_wr ? STEP_WR_END : STEP_RD_STOP;
          end
          else
          begin
            if (!i_wr && stp == STEP_RD_DATA)
              ext_rdata <= rxsh;
            stp <= stp + 4'h1;
            txsh <= {step_byte(stp + 4'h1, ctl, eaddr, wbyte), 1'b1};
          end
        end
      end
    end
  end

  logic push, pop;
  assign push = (st == ST_SCAN) && !is_wr && op_done && !op_fail;
  assign pop = rd_valid_o && rd_ready_i;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      tail_v <= 1'b0;
      tail_data <= 8'h00;
    end
    else if (push && (!rd_valid_o || (pop && !tail_v)))
    begin
      rd_valid_o <= 1'b1;
      rd_data_o <= op_rdata;
    end
    else if (push && pop)
    begin
      rd_data_o <= tail_data;
      tail_data <= op_rdata;
    end
    else if (push)
    begin
      tail_v <= 1'b1;
      tail_data <= op_rdata;
    end
    else if (pop)
    begin
      rd_valid_o <= tail_v;
      rd_data_o <= tail_data;
      tail_v <= 1'b0;
    end
  end

  // Status and system hold outputs
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      {busy_o, done_o, refused_o, memory_failure_error_o, irq_hold_o, radio_suspend_o} <= 6'h00;
    else
    begin
      // Raised on the taking edge, so a second request is never offered
      busy_o <= (st != ST_IDLE) || read_run_request_i || write_run_request_i;
      done_o <= (st == ST_FINISH);
      refused_o <= (st == ST_FINISH) && fin_ref;
      memory_failure_error_o <= (st == ST_FINISH) && fin_err;
      irq_hold_o <= (st != ST_IDLE && st != ST_FINISH && !fin_ref) && (ext
                    || (flash && (st == ST_ERASE || st == ST_PROG || st == ST_VERIFY)));
      radio_suspend_o <= (st != ST_IDLE && st != ST_FINISH && !fin_ref) && (ext
                    || (flash && (st == ST_ERASE || st == ST_PROG || st == ST_VERIFY)));
    end
  end

endmodule
`default_nettype wire

//--- bench/mmm_properties.sv
`timescale 1ns/100ps
`default_nettype none
// Port-level watch on the memory manager
module mmm_checker
  import mmm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic read_run_request_i,
  input wire logic write_run_request_i,
  input wire logic [7:0] storage_code_i,
  input wire logic [15:0] offset_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic refused_o,
  input wire logic memory_failure_error_o,
  input wire logic irq_hold_o,
  input wire logic radio_suspend_o,
  input wire logic mem_req_o,
  input wire logic mem_ack_i,
  input wire logic [1:0] mem_op_o,
  input wire logic [1:0] mem_sel_o,
  input wire logic [23:0] mem_addr_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  // A request meets an idle engine
  sequence s_take;
    !busy_o && (read_run_request_i || write_run_request_i);
  endsequence
  // Refusal answers two edges after the take
  sequence s_refuse;
    ##2 (done_o && refused_o);
  endsequence
  a_busy_on_take: assert property (s_take |=> busy_o)
    else $error("busy not raised after take");
  a_low_flash_ref: assert property (s_take ##0 (storage_code_i == 8'h80 && offset_i < 16'hC000)
    |-> s_refuse) else $error("low flash not refused");
  a_fail_with_done: assert property (memory_failure_error_o |-> done_o)
    else $error("failure without done");
  a_done_then_idle: assert property (done_o |=> !busy_o && !done_o)
    else $error("done not a single closing pulse");
  a_mem_req_held: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
    else $error("memory request dropped early");
  // Mapped RAM window only, never below or above it
  a_ram_window: assert property (mem_req_o && mem_sel_o == 2'h0
    |-> mem_addr_o >= 24'h000100 && mem_addr_o <= 24'h0009FF) else $error("RAM out of window");
  a_flash_floor: assert property (mem_req_o && mem_sel_o == 2'h2 |-> mem_addr_o >= 24'h00C000)
    else $error("protected flash touched");
  a_flash_hold: assert property (mem_req_o && mem_sel_o == 2'h2 && mem_op_o != 2'h0
    |-> irq_hold_o && radio_suspend_o) else $error("flash change without hold");
endmodule
bind mmm_memory_manager mmm_checker mmm_checker_inst (.*);
`default_nettype wire

//--- bench/mmm_serial_mem.sv
`timescale 1ns/100ps
`default_nettype none
// Serial memory stand-in: acks its own control byte and written bytes
module mmm_serial_mem #(parameter logic [2:0] STRAP = 3'h0)
(
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_rel_o
);
  logic [7:0] sh = 8'h00; // Bits seen, newest at the bottom
  int bits = 0; // Bits since the last start
  logic sel = 1'h0; // Addressed in this frame
  logic rd = 1'h0; // Frame reads, so data bytes are not acked
  logic [7:0] dat = 8'h00; // Low offset byte, echoed as read data
  initial sda_rel_o = 1'h1;
  // Start: data falls while the clock is high
  always @(negedge sda_i)
    if (scl_i)
      bits = 0;
  always @(posedge scl_i)
  begin
    sh = {sh[6:0], sda_i};
    bits++;
  end
  // Release by default; read data echoes the low offset byte
  always @(negedge scl_i)
  begin
    if (bits == 26)
      dat = sh;
    if (bits == 8)
      {sel, rd} = {sh[7:1] == {4'hB, STRAP}, sh[0]};
    if (sel && rd && bits >= 9 && bits < 17)
      sda_rel_o = dat[16 - bits];
    else
      sda_rel_o = !(bits % 9 == 8 && sel && (bits == 8 || !rd));
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import mmm_pkg::*;
;
  logic clk_i = '0, rstn_i = '0, read_run_request_i = '0, write_run_request_i = '0;
  logic serial_fast_i = '1, primary_valid_i = '1, alternate_valid_i = '1, rd_ready_i = '1;
  logic [7:0] storage_code_i = '0, primary_data_i = 8'h3C, alternate_data_i = 8'hA5;
  logic [15:0] offset_i = '0, alt_pointer_i = '0;
  logic [6:0] byte_count_i = 7'h01;
  logic primary_ready_o, alternate_ready_o, rd_valid_o, busy_o, done_o, refused_o, sda_rel;
  logic memory_failure_error_o, irq_hold_o, radio_suspend_o, mem_req_o, scl_o, scl_oe_n_o;
  logic sda_o, sda_oe_n_o, ref_seen, fail_seen, mem_ack_i = '0, hold_seen = '0, mem_wait = '0;
  logic [1:0] mem_op_o, mem_sel_o;
  logic [7:0] rd_data_o, mem_wdata_o, mem_rdata_i = '0;
  logic [23:0] mem_addr_o, last_ra;
  logic [7:0] store [0:4095] = '{default: 8'h00}; // Internal stores, folded
  logic [7:0] rxq [$]; // Bytes taken from the read stream
  int err_total = 0, checks_done = 0, wcount = 0;
  // Open-drain lines with pull-ups
  wire logic scl_i = scl_oe_n_o;
  wire logic sda_i = sda_oe_n_o & sda_rel;
  mmm_memory_manager #(.POLL_MAX(4)) mmm_memory_manager_inst (.*);
  mmm_serial_mem mmm_serial_mem_inst (.scl_i(scl_i), .sda_i(sda_i), .sda_rel_o(sda_rel));
  always #2.5 clk_i = !clk_i;
  // Reads answer at once, writes and erases after one wait state
  always @(negedge clk_i)
  begin
    mem_wait <= mem_req_o && !mem_ack_i;
    mem_ack_i <= mem_req_o && !mem_ack_i && (mem_wait || mem_op_o == 2'h0);
    mem_rdata_i <= store[mem_addr_o[11:0]];
    if (mem_req_o && !mem_ack_i && mem_wait && mem_op_o == 2'h1)
      {store[mem_addr_o[11:0]], wcount} <= {mem_wdata_o, wcount + 1};
    if (mem_req_o && mem_op_o == 2'h0)
      last_ra <= mem_addr_o;
  end
  always @(posedge clk_i)
  begin
    if (alternate_valid_i && alternate_ready_o)
      alternate_data_i <= alternate_data_i + 8'h01;
    if (rd_valid_o && rd_ready_i)
      rxq.push_back(rd_data_o);
    if (irq_hold_o)
      hold_seen <= 1'h1;
  end
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'h1)
    begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  // One request, waited for under a bound; stream settles after done
  task automatic run(logic wr, logic [7:0] c, logic [15:0] o, logic [6:0] n, logic [15:0] p);
    rxq.delete();
    {write_run_request_i, read_run_request_i, storage_code_i} = {wr, !wr, c};
    {offset_i, byte_count_i, alt_pointer_i} = {o, n, p};
    @(negedge clk_i);
    {write_run_request_i, read_run_request_i} = 2'h0;
    for (int k = 0; k < 40000 && done_o !== 1'h1; k++)
      @(negedge clk_i);
    check(done_o === 1'h1, "request never finished");
    {ref_seen, fail_seen} = {refused_o, memory_failure_error_o};
    repeat (4) @(negedge clk_i);
  endtask
  task automatic t_refuse;
    logic [7:0] c [3] = '{8'h80, 8'h02, 8'h05};
    logic [15:0] o [3] = '{16'hBFFF, 16'h08FF, 16'h0000};
    for (int i = 0; i < 3; i++)
    begin
      run(1'h1, c[i], o[i], 7'h02, 16'h0000);
      check(ref_seen, "request not refused");
    end
  endtask
  task automatic t_map;
    logic [7:0] c [4] = '{8'h80, 8'h81, 8'h01, 8'h03};
    logic [15:0] o [4] = '{16'hC010, 16'h0010, 16'h0010, 16'h03FF};
    logic [23:0] a [4] = '{24'h00C010, 24'h010010, 24'h010010, 24'h0003FF};
    for (int i = 0; i < 4; i++)
    begin
      run(1'h0, c[i], o[i], 7'h01, 16'h0000);
      check(last_ra === a[i] && ref_seen === 1'h0, "wrong address");
    end
  endtask
  task automatic t_ram_flash;
    int w0;
    run(1'h1, 8'h02, 16'h0005, 7'h02, 16'h0200);
    check(store[12'h105] === 8'hA5 && store[12'h106] === 8'hA6, "RAM write");
    run(1'h0, 8'h02, 16'h0005, 7'h02, 16'h0000);
    check(rxq.size() == 2 && rxq[0] === 8'hA5 && rxq[1] === 8'hA6, "RAM read");
    w0 = wcount;
    run(1'h1, 8'h81, 16'h0045, 7'h01, 16'h0000);
    check(wcount - w0 == 64 && store[12'h045] === 8'h3C, "flash block");
    w0 = wcount;
    run(1'h1, 8'h81, 16'h0045, 7'h01, 16'h0000);
    check(wcount == w0 && fail_seen === 1'h0, "rewrite not skipped");
  endtask
  task automatic t_serial;
    time t0;
    hold_seen = 1'h0;
    run(1'h0, 8'h10, 16'h0007, 7'h01, 16'h0000);
    check(rxq.size() == 1 && rxq[0] === 8'h07 && hold_seen && !fail_seen, "serial read");
    serial_fast_i = 1'h0;
    t0 = $time;
    run(1'h0, 8'h11, 16'h0007, 7'h01, 16'h0000);
    check(fail_seen, "absent memory accepted");
    check($time - t0 > 90000, "slow bus rate not used");
  endtask
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk_i);
    rstn_i = 1'h1;
    t_refuse();
    t_map();
    t_ram_flash();
    t_serial();
    end_of_test();
  end
  // Serial read dominates; this leaves ample margin
  initial
  begin
    #400000;
    err_total++;
    end_of_test();
  end
endmodule
`default_nettype wire
